/* File: hw/bit_clear_unit.sv */
// Address forming and bit clearing for the bit clear instruction.
// Assumes the caller holds operands stable through phases 2 to 4.
`default_nettype none
`include "cbbc_defs.svh"

module bit_clear_unit (
	input wire logic [7:0] file_addr_i,
	input wire logic access_sel_i,
	input wire logic ext_set_en_i,
	input wire logic [3:0] bank_select_register_i,
	input wire logic [11:0] index_base_i,
	input wire logic [2:0] bit_sel_i,
	input wire logic [7:0] data_i,
	output logic [11:0] addr_o,
	output logic [7:0] data_o
);

	// ------------------------------------------------------------
	// Address selection
	// ------------------------------------------------------------
	// Indexed mode first, then access bank, then banked access
	always_comb begin
		if (!access_sel_i && ext_set_en_i && file_addr_i <= `CBBC_IDX_LIMIT) begin
			addr_o = index_base_i + {4'h0, file_addr_i};
		end else if (!access_sel_i) begin
			// Access bank: low half from bank 0, high half from top bank
			if (file_addr_i < `CBBC_ACC_SPLIT) begin
				addr_o = {4'h0, file_addr_i};
			end else begin
				addr_o = {`CBBC_ACC_HI_BANK, file_addr_i};
			end
		end else begin
			addr_o = {bank_select_register_i, file_addr_i};
		end
	end

	// ------------------------------------------------------------
	// Bit clear
	// ------------------------------------------------------------
	// Each bit passes unless it is the selected one
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_bit
			assign data_o[gi] = data_i[gi] & (bit_sel_i != 3'(gi));
		end
	endgenerate

endmodule

`default_nettype wire

/* File: hw/cbbc_defs.svh */
// Constants for the conditional branch and bit clear executor.
// Assumes inclusion by bare name from the design files under hw/.
`ifndef CBBC_DEFS_SVH
`define CBBC_DEFS_SVH

// ------------------------------------------------------------
// Widths
// ------------------------------------------------------------
`define CBBC_PC_W 21
`define CBBC_DADDR_W 12

// ------------------------------------------------------------
// Opcode fields
// ------------------------------------------------------------
`define CBBC_OP_BR_CARRY 8'hE2
`define CBBC_OP_BR_NEG 8'hE6
`define CBBC_OP_BITCLR 4'h9

// ------------------------------------------------------------
// Data memory addressing
// ------------------------------------------------------------
`define CBBC_IDX_LIMIT 8'h5F
`define CBBC_ACC_SPLIT 8'h80
`define CBBC_ACC_HI_BANK 4'hF

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define CBBC_RST_PC 21'h000000
`define CBBC_RST_ADDR 12'h000
`define CBBC_RST_DATA 8'h00

`endif

/* File: hw/cbbc_pkg.sv */
// Types shared by the conditional branch and bit clear executor.
// Assumes no other package.
`default_nettype none

package cbbc_pkg;

	// Four phases of one instruction cycle
	typedef enum logic [1:0] {
		PH_Q1,
		PH_Q2,
		PH_Q3,
		PH_Q4
	} phase_t;

	// Decoded operation held for the cycle
	typedef enum logic [1:0] {
		OP_NONE,
		OP_BR_CARRY,
		OP_BR_NEG,
		OP_BITCLR
	} op_t;

endpackage

`default_nettype wire

/* File: hw/cond_branch_bit_clear_exec.sv */
// Executes the carry branch, negative branch and bit clear instructions.
// Assumes the fetch unit presents a word in phase 1 with an incremented PC,
// and that data memory returns read data within the same phase.
`default_nettype none
`include "cbbc_defs.svh"

module cond_branch_bit_clear_exec (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [15:0] instr_i,
	input wire logic instr_valid_i,
	input wire logic [20:0] pc_incr_i,
	input wire logic carry_i,
	input wire logic negative_i,
	input wire logic ext_set_en_i,
	input wire logic [3:0] bank_select_register_i,
	input wire logic [11:0] index_base_i,
	input wire logic [7:0] mem_rdata_i,
	output logic [1:0] phase_o,
	output logic [11:0] mem_addr_o,
	output logic mem_rd_o,
	output logic mem_wr_o,
	output logic [7:0] mem_wdata_o,
	output logic pc_load_o,
	output logic [20:0] pc_target_o,
	output logic nop_cycle_o
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	cbbc_pkg::phase_t phase_reg;
	cbbc_pkg::phase_t phase_next;
	cbbc_pkg::op_t op_reg;
	cbbc_pkg::op_t op_next;
	logic [15:0] instr_reg;
	logic [7:0] offset_reg;
	logic [7:0] rdata_reg;
	logic taken_reg;
	// Combinational results feeding the output registers
	logic [11:0] bc_addr;
	logic [7:0] bc_data;
	logic [20:0] target_next;

	// ------------------------------------------------------------
	// Phase sequencer
	// ------------------------------------------------------------
	// Next phase rolls Q1 to Q4 then back to Q1
	always_comb begin
		unique case (phase_reg)
			cbbc_pkg::PH_Q1: phase_next = cbbc_pkg::PH_Q2;
			cbbc_pkg::PH_Q2: phase_next = cbbc_pkg::PH_Q3;
			cbbc_pkg::PH_Q3: phase_next = cbbc_pkg::PH_Q4;
			cbbc_pkg::PH_Q4: phase_next = cbbc_pkg::PH_Q1;
		endcase
	end

	// Phase register, mirrored on the phase output
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			phase_reg <= cbbc_pkg::PH_Q1;
			phase_o <= 2'h0;
		end else begin
			phase_reg <= phase_next;
			phase_o <= phase_next;
		end
	end

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	// Opcode match on the presented word; anything else is not ours
	always_comb begin
		op_next = cbbc_pkg::OP_NONE;
		if (instr_valid_i && !nop_cycle_o) begin
			if (instr_i[15:8] == `CBBC_OP_BR_CARRY) begin
				op_next = cbbc_pkg::OP_BR_CARRY;
			end else if (instr_i[15:8] == `CBBC_OP_BR_NEG) begin
				op_next = cbbc_pkg::OP_BR_NEG;
			end else if (instr_i[15:12] == `CBBC_OP_BITCLR) begin
				op_next = cbbc_pkg::OP_BITCLR;
			end
		end
	end

	// Decoded operation and word captured at the end of Q1
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			op_reg <= cbbc_pkg::OP_NONE;
			instr_reg <= 16'h0000;
		end else if (phase_reg == cbbc_pkg::PH_Q1) begin
			op_reg <= op_next;
			instr_reg <= instr_i;
		end else if (phase_reg == cbbc_pkg::PH_Q4) begin
			op_reg <= cbbc_pkg::OP_NONE;
		end
	end

	// ------------------------------------------------------------
	// Bit clear datapath
	// ------------------------------------------------------------
	bit_clear_unit u_bit_clear (
		.file_addr_i(instr_reg[7:0]),
		.access_sel_i(instr_reg[8]),
		.ext_set_en_i(ext_set_en_i),
		.bank_select_register_i(bank_select_register_i),
		.index_base_i(index_base_i),
		.bit_sel_i(instr_reg[11:9]),
		.data_i(rdata_reg),
		.addr_o(bc_addr),
		.data_o(bc_data)
	);

	// Read strobe stands through Q2; the address is registered at the end of Q2
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mem_rd_o <= 1'b0;
		end else begin
			mem_rd_o <= (phase_reg == cbbc_pkg::PH_Q1) && (op_next == cbbc_pkg::OP_BITCLR);
		end
	end

	// Address is formed from the captured word at the end of Q2, held for the rest of the cycle
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mem_addr_o <= `CBBC_RST_ADDR;
		end else if (phase_reg == cbbc_pkg::PH_Q2 && op_reg == cbbc_pkg::OP_BITCLR) begin
			mem_addr_o <= bc_addr;
		end
	end

	// Read data sampled at the end of Q2
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_reg <= `CBBC_RST_DATA;
		end else if (phase_reg == cbbc_pkg::PH_Q2 && op_reg == cbbc_pkg::OP_BITCLR) begin
			rdata_reg <= mem_rdata_i;
		end
	end

	// Modified byte prepared in Q3, written during Q4
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mem_wr_o <= 1'b0;
			mem_wdata_o <= `CBBC_RST_DATA;
		end else if (phase_reg == cbbc_pkg::PH_Q3 && op_reg == cbbc_pkg::OP_BITCLR) begin
			mem_wr_o <= 1'b1;
			mem_wdata_o <= bc_data;
		end else begin
			mem_wr_o <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Branch datapath
	// ------------------------------------------------------------
	// Offset literal read in Q2
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			offset_reg <= 8'h00;
		end else if (phase_reg == cbbc_pkg::PH_Q2) begin
			offset_reg <= instr_reg[7:0];
		end
	end

	// Incremented PC plus the sign-extended offset doubled
	assign target_next = 21'(pc_incr_i + {{12{offset_reg[7]}}, offset_reg, 1'b0});

	// Condition evaluated in Q3; no flag is ever written by this block
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			taken_reg <= 1'b0;
		end else if (phase_reg == cbbc_pkg::PH_Q3) begin
			taken_reg <= (op_reg == cbbc_pkg::OP_BR_CARRY && carry_i)
				|| (op_reg == cbbc_pkg::OP_BR_NEG && negative_i);
		end else if (phase_reg == cbbc_pkg::PH_Q4) begin
			taken_reg <= 1'b0;
		end
	end

	// PC load strobe and target stand through Q4 of a taken branch
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pc_load_o <= 1'b0;
			pc_target_o <= `CBBC_RST_PC;
		end else if (phase_reg == cbbc_pkg::PH_Q3) begin
			pc_load_o <= (op_reg == cbbc_pkg::OP_BR_CARRY && carry_i)
				|| (op_reg == cbbc_pkg::OP_BR_NEG && negative_i);
			pc_target_o <= target_next;
		end else begin
			pc_load_o <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Pipeline refill cycle
	// ------------------------------------------------------------
	// A taken branch makes the following whole cycle a no-operation
	// Flag falls at the Q4 edge of the skipped cycle, as taken_reg is clear then;
	// decode refuses every word offered while it stands
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			nop_cycle_o <= 1'b0;
		end else if (phase_reg == cbbc_pkg::PH_Q4) begin
			nop_cycle_o <= taken_reg;
		end
	end

endmodule

`default_nettype wire

/* File: testbench/cbbc_checker.sv */
// Assertions on the ports of the branch and bit clear executor.
// Assumes a bind onto the top module and a single clock domain.
`default_nettype none

module cbbc_checker (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [15:0] instr_i,
	input wire logic instr_valid_i,
	input wire logic [20:0] pc_incr_i,
	input wire logic carry_i,
	input wire logic negative_i,
	input wire logic ext_set_en_i,
	input wire logic [3:0] bank_select_register_i,
	input wire logic [11:0] index_base_i,
	input wire logic [7:0] mem_rdata_i,
	input wire logic [1:0] phase_o,
	input wire logic [11:0] mem_addr_o,
	input wire logic mem_rd_o,
	input wire logic mem_wr_o,
	input wire logic [7:0] mem_wdata_o,
	input wire logic pc_load_o,
	input wire logic [20:0] pc_target_o,
	input wire logic nop_cycle_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Accepted word at the end of Q1
	wire logic go = phase_o == 2'h0 && instr_valid_i && !nop_cycle_o;
	wire logic [7:0] op = instr_i[15:8];
	sequence s_bc; go && op == 8'hE2 ##2 carry_i; endsequence
	sequence s_bn; go && op == 8'hE6 ##2 negative_i; endsequence
	sequence s_nt; go && op == 8'hE2 ##2 !carry_i; endsequence
	sequence s_clr; go && instr_i[15:12] == 4'h9; endsequence
	// Offset sign extended and doubled
	function automatic logic [20:0] sx(input logic [7:0] n);
		return {{12{n[7]}}, n, 1'b0};
	endfunction
	// Data address from access bit, mode and file address
	function automatic logic [11:0] ea(input logic [8:0] af, input logic e,
		input logic [3:0] b, input logic [11:0] x);
		if (af[8]) return {b, af[7:0]};
		if (e && af[7:0] <= 8'h5F) return x + {4'h0, af[7:0]};
		return {af[7] ? 4'hF : 4'h0, af[7:0]};
	endfunction
	property p_bc_taken; s_bc |=> pc_load_o ##1 nop_cycle_o [*4] ##1 !nop_cycle_o; endproperty
	a_bc_taken: assert property (p_bc_taken) else $error("carry branch timing");
	property p_bn_taken; s_bn |=> pc_load_o; endproperty
	a_bn_taken: assert property (p_bn_taken) else $error("negative branch missed");
	property p_nt; s_nt |=> !pc_load_o ##1 !nop_cycle_o; endproperty
	a_nt: assert property (p_nt) else $error("branch taken without carry");
	property p_target;
		pc_load_o |-> pc_target_o == $past(pc_incr_i) + sx($past(instr_i[7:0], 3));
	endproperty
	a_target: assert property (p_target) else $error("wrong branch target");
	property p_cause;
		pc_load_o |-> $past(instr_i[15:8], 3) == 8'hE2 && $past(carry_i)
			|| $past(instr_i[15:8], 3) == 8'hE6 && $past(negative_i);
	endproperty
	a_cause: assert property (p_cause) else $error("load without cause");
	property p_clr; s_clr |=> mem_rd_o ##1 !mem_rd_o ##1 mem_wr_o ##1 !mem_wr_o; endproperty
	a_clr: assert property (p_clr) else $error("bit clear phases");
	property p_wdata;
		mem_wr_o |-> mem_wdata_o == ($past(mem_rdata_i, 2) & ~(8'h01 << $past(instr_i[11:9], 3)));
	endproperty
	a_wdata: assert property (p_wdata) else $error("wrong byte written");
	property p_addr;
		mem_wr_o |-> mem_addr_o == ea($past(instr_i[8:0], 3), $past(ext_set_en_i, 2),
			$past(bank_select_register_i, 2), $past(index_base_i, 2));
	endproperty
	a_addr: assert property (p_addr) else $error("wrong data address");
	property p_pc_q4; pc_load_o |-> phase_o == 2'h3 && !mem_wr_o; endproperty
	a_pc_q4: assert property (p_pc_q4) else $error("pc load out of Q4");
endmodule

bind cond_branch_bit_clear_exec cbbc_checker cbbc_checker_inst (.*);

`default_nettype wire

/* File: testbench/cbbc_mem_model.sv */
// Data memory stand-in for bit clear reads and writes.
// Assumes the bench sets the stored byte before each access.
`default_nettype none

module cbbc_mem_model (
	input wire logic clk_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic [7:0] wdata_i,
	input wire logic [7:0] byte_i,
	output logic [7:0] rdata_o,
	output logic [7:0] last_wr_o
);
	// Valid only while read; inverted otherwise
	assign rdata_o = rd_i ? byte_i : ~byte_i;
	// Keep the last byte written
	always_ff @(posedge clk_i) begin
		if (wr_i) last_wr_o <= wdata_i;
	end
endmodule

`default_nettype wire

/* File: testbench/cond_branch_bit_clear_exec_tb.sv */
// Self-checking bench for the branch and bit clear executor.
// Assumes a 250 MHz clock and the memory model on the data side.
`default_nettype none

module cond_branch_bit_clear_exec_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [15:0] instr_i = 16'h0000;
	logic instr_valid_i = 1'b0;
	logic [20:0] pc_incr_i = 21'h000010;
	logic carry_i = 1'b0;
	logic negative_i = 1'b0;
	logic ext_set_en_i = 1'b0;
	logic [3:0] bank_select_register_i = 4'h5;
	logic [11:0] index_base_i = 12'h200;
	logic [7:0] rbyte = 8'h00;
	logic [7:0] mem_rdata_i, mem_wdata_o, last_wr;
	logic [1:0] phase_o;
	logic [11:0] mem_addr_o;
	logic mem_rd_o, mem_wr_o, pc_load_o, nop_cycle_o;
	logic [20:0] pc_target_o;
	int errors = 0;
	int num_checks = 0;
	always #2 clk_i = ~clk_i;
	cond_branch_bit_clear_exec cond_branch_bit_clear_exec_inst (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.instr_i(instr_i),
		.instr_valid_i(instr_valid_i),
		.pc_incr_i(pc_incr_i),
		.carry_i(carry_i),
		.negative_i(negative_i),
		.ext_set_en_i(ext_set_en_i),
		.bank_select_register_i(bank_select_register_i),
		.index_base_i(index_base_i),
		.mem_rdata_i(mem_rdata_i),
		.phase_o(phase_o),
		.mem_addr_o(mem_addr_o),
		.mem_rd_o(mem_rd_o),
		.mem_wr_o(mem_wr_o),
		.mem_wdata_o(mem_wdata_o),
		.pc_load_o(pc_load_o),
		.pc_target_o(pc_target_o),
		.nop_cycle_o(nop_cycle_o)
	);
	cbbc_mem_model cbbc_mem_model_inst (.clk_i(clk_i), .rd_i(mem_rd_o), .wr_i(mem_wr_o),
		.wdata_i(mem_wdata_o), .byte_i(rbyte), .rdata_o(mem_rdata_i), .last_wr_o(last_wr));
	// Compare, count and report
	task automatic chk(input string s, input logic [20:0] seen, input logic [20:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s exp %h seen %h", s, exp, seen);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Hold a word across the edge that ends Q1
	task automatic issue(input logic [15:0] w);
		while (phase_o !== 2'h0 || nop_cycle_o !== 1'b0) @(negedge clk_i);
		instr_i = w;
		instr_valid_i = 1'b1;
		@(negedge clk_i);
		instr_valid_i = 1'b0;
	endtask
	// Collect any strobe over n cycles
	task automatic quiet(input int n, inout logic s);
		repeat (n) begin
			@(negedge clk_i);
			s = s | mem_rd_o | mem_wr_o | pc_load_o;
		end
	endtask
	// Branches of both kinds, taken and not, range ends of the offset
	task automatic t_branch;
		logic [15:0] w [5] = '{16'hE205, 16'hE280, 16'hE27F, 16'hE67F, 16'hE680};
		logic [4:0] c = 5'b10011;
		logic [4:0] n = 5'b01100;
		logic tk;
		for (int i = 0; i < 5; i++) begin
			tk = (w[i][15:8] == 8'hE2 && c[i]) || (w[i][15:8] == 8'hE6 && n[i]);
			carry_i = c[i];
			negative_i = n[i];
			issue(w[i]);
			for (int k = 0; k < 4 && !pc_load_o; k++) @(negedge clk_i);
			chk("pc_load", 21'(pc_load_o), 21'(tk));
			if (tk) begin
				chk("phase_pc", 21'(phase_o), 21'h3);
				chk("target", pc_target_o, 21'h10 + {{12{w[i][7]}}, w[i][7:0], 1'b0});
				@(negedge clk_i);
				chk("nop", 21'(nop_cycle_o), 21'h1);
			end
		end
		$display("test branch done");
	endtask
	// Bit clear in each addressing mode and at the indexed limit
	task automatic t_clear;
		logic [15:0] w [5] = '{16'h9E12, 16'h9085, 16'h9334, 16'h9A5F, 16'h9C60};
		logic [11:0] a [5] = '{12'h012, 12'hF85, 12'h534, 12'h25F, 12'h060};
		logic [7:0] d [5] = '{8'hC7, 8'hFF, 8'h02, 8'h3F, 8'h7F};
		logic [4:0] e = 5'b11110;
		for (int i = 0; i < 5; i++) begin
			ext_set_en_i = e[i];
			rbyte = d[i];
			issue(w[i]);
			chk("rd", 21'(mem_rd_o), 21'h1);
			chk("phase", 21'(phase_o), 21'h1);
			for (int k = 0; k < 4 && !mem_wr_o; k++) @(negedge clk_i);
			chk("addr", 21'(mem_addr_o), 21'(a[i]));
			chk("wdata", 21'(mem_wdata_o), 21'(d[i] & ~(8'h01 << w[i][11:9])));
			@(negedge clk_i);
			chk("byte", 21'(last_wr), 21'(d[i] & ~(8'h01 << w[i][11:9])));
		end
		$display("test clear done");
	endtask
	// Words offered in the skipped cycle and an unknown opcode
	task automatic t_refuse;
		logic s = 1'b0;
		carry_i = 1'b1;
		issue(16'hE201);
		repeat (3) @(negedge clk_i);
		instr_i = 16'h9000;
		instr_valid_i = 1'b1;
		quiet(4, s);
		instr_valid_i = 1'b0;
		chk("skipped", 21'(s), 21'h0);
		negative_i = 1'b1;
		issue(16'hE301);
		quiet(6, s);
		chk("unknown", 21'(s | nop_cycle_o), 21'h0);
		instr_i = 16'hE201;
		quiet(8, s);
		chk("invalid", 21'(s | nop_cycle_o), 21'h0);
		$display("test refuse done");
	endtask
	// Reset in the middle of a taken branch, then a bit clear after release
	task automatic t_reset;
		carry_i = 1'b1;
		issue(16'hE203);
		repeat (2) @(negedge clk_i);
		chk("pre_rst_load", 21'(pc_load_o), 21'h1);
		rst_i = 1'b1;
		@(negedge clk_i);
		chk("rst_load", 21'(pc_load_o), 21'h0);
		chk("rst_phase", 21'(phase_o), 21'h0);
		chk("rst_nop", 21'(nop_cycle_o), 21'h0);
		rst_i = 1'b0;
		rbyte = 8'hA5;
		issue(16'h9F10);
		chk("rst_rd", 21'(mem_rd_o), 21'h1);
		chk("rst_ph", 21'(phase_o), 21'h1);
		repeat (2) @(negedge clk_i);
		chk("rst_wr", 21'(mem_wr_o), 21'h1);
		chk("rst_addr", 21'(mem_addr_o), 21'h510);
		chk("rst_wdata", 21'(mem_wdata_o), 21'h25);
		$display("test reset done");
	endtask
	// Main sequence
	initial begin
		repeat (3) @(negedge clk_i);
		rst_i = 1'b0;
		t_branch();
		t_clear();
		t_refuse();
		t_reset();
		end_sim();
	end
	// Watchdog well past the span of all tests
	initial begin
		repeat (400) @(posedge clk_i);
		errors++;
		end_sim();
	end
endmodule

`default_nettype wire
